// file: ssh_map.svh
// Purpose: Constants for the stepper S-curve, position and homing logic
// Assumes: 10 MHz mclk_in, synchronous pins
// Notes:   Timing counts in mclk_in cycles
// Operation
// - Jerk setting 1 to 5000; physical jerk is setting times accel over 100.
// - Jerk setting zero gives constant acceleration, linear speed ramp.
// - S-curve ramps are symmetric about the speed midpoint.
// - Jerk acceleration at midpoint within programmed accel gives triangular ramp.
// - Otherwise acceleration clamps at programmed value, giving trapezoidal ramp.
// - Jerk phase lasts programmed accel divided by physical jerk.
// - Equal accel and decel values give identical ramp shapes.
// - Completing a home search loads zero into motor position.
// - Home completion clears encoder position when encoder present and enabled.
// - All moves run unhomed except absolute moves, refused until homed.
// - Separate motor and encoder presets plus encoder-to-motor copy.
// - Preset values accepted only within plus or minus 8388607.
// - Encoder copy scaled by motor steps over encoder counts per turn.
// - Hard-stop homing needs a fitted encoder and enabled stall detection; here a stall only sets stall_out and homing ends on the home sensor.
// - After stall host issues error clear; device returns stall flag to zero.
// - Motor position preset clears the position-invalid bit.
// - Jog command carries a current setting, applied while jogging.
// - Clockwise search starts clockwise, ends on sensor at starting speed clockwise.
// - Counterclockwise search mirrors clockwise, starting and ending counterclockwise.
`ifndef SSH_MAP_SVH
`define SSH_MAP_SVH
`define SSH_JERK_MAX      16'd5000
`define SSH_JERK_DIV      100
`define SSH_POS_LIMIT     24'sd8388607
`define SSH_RATE_HZ       10000000
`define SSH_TICK_HZ       1000
`define SSH_TICK_CYC      (`SSH_RATE_HZ / `SSH_TICK_HZ)
`define SSH_SPEED_W       24
`define SSH_POS_W         24
`endif

// file: ssh_pkg.sv
// Purpose: Types for the stepper S-curve, position and homing logic
// Assumes: Constants in ssh_map.svh
// Notes:   Command codes and profile settings
package ssh_pkg;
  typedef enum logic [3:0] {
    SSH_CMD_NONE,
    SSH_CMD_REL_MOVE,
    SSH_CMD_ABS_MOVE,
    SSH_CMD_JOG_CW,
    SSH_CMD_JOG_CCW,
    SSH_CMD_HOME_CW,
    SSH_CMD_HOME_CCW,
    SSH_CMD_PRESET_MOTOR,
    SSH_CMD_PRESET_ENC,
    SSH_CMD_ENC_TO_MOTOR,
    SSH_CMD_CLEAR_ERR,
    SSH_CMD_STOP
  } ssh_cmd_t;

  typedef struct packed {
    logic [23:0] start_speed;
    logic [23:0] prog_speed;
    logic [23:0] accel;
    logic [23:0] decel;
    logic [15:0] jerk;
  } ssh_profile_t;

  typedef struct packed {
    logic [15:0] steps_per_turn;
    logic [15:0] counts_per_turn;
    logic        encoder_en;
    logic        stall_en;
  } ssh_config_t;

  typedef struct packed {
    ssh_cmd_t           code;
    logic signed [23:0] value;
    logic [7:0]         current;
  } ssh_command_t;
endpackage

// file: ssh_ramp.sv
// Purpose: One S-curve or linear speed ramp
// Assumes: tick_in is a one-cycle rate enable
// Notes:   Speed steps per tick; symmetric about midpoint
`timescale 1ns/1ps
`include "ssh_map.svh"
module ssh_ramp #(
  parameter int W = 24
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic         tick_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] from_in,
  input  wire logic [W-1:0] to_in,
  input  wire logic [W-1:0] accel_in,
  input  wire logic [15:0]  jerk_in,
  output logic      [W-1:0] speed_out,
  output logic              busy_out
);
  typedef enum {SSH_R_IDLE, SSH_R_RISE, SSH_R_HOLD, SSH_R_FALL, SSH_R_LIN} ssh_rstate_t;
  ssh_rstate_t state;
  logic [W-1:0]  speed;
  logic [W-1:0]  acc;
  logic [W-1:0]  rise_spd;
  logic          up;
  logic [W-1:0]  target;
  logic [W+15:0] jprod;
  wire  [W-1:0]  jrate;
  wire  [W-1:0]  dist_left;
  wire  [W-1:0]  dist_done;
  wire  [W-1:0]  acc_next;
  wire           at_mid;
  wire           clamp;
  wire  [W-1:0]  step;

  assign jprod     = {16'h0000, accel_in} * {{W{1'b0}}, jerk_in};
  assign jrate     = W'((jprod / `SSH_JERK_DIV) / `SSH_TICK_HZ) | W'(1);
  assign dist_left = up ? target - speed : speed - target;
  assign dist_done = up ? speed - from_in : from_in - speed;
  assign acc_next  = acc + jrate;
  assign at_mid    = dist_done >= dist_left;
  assign clamp     = acc_next >= accel_in;
  assign step      = (state == SSH_R_LIN) ? accel_in | W'(1) : acc;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= SSH_R_IDLE;
      speed    <= '0;
      acc      <= '0;
      rise_spd <= '0;
      up       <= 1'b1;
      target   <= '0;
    end else if (start_in) begin
      speed    <= from_in;
      target   <= to_in;
      up       <= to_in >= from_in;
      acc      <= '0;
      rise_spd <= '0;
      state    <= (jerk_in == 16'h0000) ? SSH_R_LIN : SSH_R_RISE;
    end else if (tick_in) begin
      unique case (state)
        SSH_R_IDLE: begin
          acc <= '0;
        end
        SSH_R_LIN, SSH_R_RISE, SSH_R_HOLD, SSH_R_FALL: begin
          if (dist_left <= step || (state == SSH_R_FALL && acc == '0)) begin
            speed <= target;
            state <= SSH_R_IDLE;
          end else begin
            speed <= up ? speed + step : speed - step;
            if (state == SSH_R_RISE) begin
              if (at_mid) begin
                state <= SSH_R_FALL;
              end else if (clamp) begin
                acc      <= accel_in;
                rise_spd <= dist_done;
                state    <= SSH_R_HOLD;
              end else begin
                acc <= acc_next;
              end
            end else if (state == SSH_R_HOLD) begin
              if (dist_left <= rise_spd) state <= SSH_R_FALL;
            end else if (state == SSH_R_FALL) begin
              acc <= (acc > jrate + 1) ? acc - jrate : W'(1);
            end
          end
        end
      endcase
    end
  end

  assign speed_out = speed;
  assign busy_out  = state != SSH_R_IDLE;
endmodule

// file: ssh_motion.sv
// Purpose: Stepper motion core: ramps, positions, presets, stall, homing
// Assumes: Synchronous pins, commands as one-cycle strobes
// Notes:   Speed units per ms tick
`timescale 1ns/1ps
`include "ssh_map.svh"
module ssh_motion #(
  parameter int TICK_CYC = `SSH_TICK_CYC
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 cmd_valid_in,
  input  wire ssh_pkg::ssh_command_t cmd_in,
  input  wire ssh_pkg::ssh_profile_t profile_in,
  input  wire ssh_pkg::ssh_config_t  config_in,
  input  wire logic                 encoder_fitted_in,
  input  wire logic                 home_sensor_in,
  input  wire logic                 stall_in,
  input  wire logic                 enc_step_in,
  input  wire logic                 enc_dir_in,
  output logic                      cmd_refused_out,
  output logic [23:0]               speed_out,
  output logic                      dir_cw_out,
  output logic                      moving_out,
  output logic [7:0]                current_out,
  output logic signed [23:0]        motor_pos_out,
  output logic signed [23:0]        enc_pos_out,
  output logic                      homed_out,
  output logic                      pos_invalid_out,
  output logic                      stall_out,
  output logic                      step_out
);
  typedef enum {SSH_M_IDLE, SSH_M_ACC, SSH_M_RUN, SSH_M_DEC, SSH_M_SEEK} ssh_mstate_t;
  ssh_mstate_t state;
  logic [$clog2(TICK_CYC+1)-1:0] div;
  logic               tick;
  logic               ramp_start;
  logic [23:0]        ramp_from;
  logic [23:0]        ramp_to;
  logic [23:0]        ramp_accel;
  wire  [23:0]        ramp_speed;
  wire                ramp_busy;
  logic [23:0]        phase;
  logic               homing;
  logic               jogging;
  logic signed [23:0] remaining;
  logic               home_prev;
  logic [7:0]         jog_current;
  logic signed [47:0] scaled;
  logic signed [23:0] enc_scaled;
  wire  ssh_pkg::ssh_cmd_t code;
  wire                in_range;
  wire                is_move;
  wire                refuse;
  wire                take;
  wire                hw_stall;
  wire                home_edge;
  wire                enc_ok;
  wire  [24:0]        phase_sum;

  assign code      = cmd_in.code;
  assign in_range  = cmd_in.value >= -`SSH_POS_LIMIT && cmd_in.value <= `SSH_POS_LIMIT;
  assign is_move   = code inside {ssh_pkg::SSH_CMD_REL_MOVE, ssh_pkg::SSH_CMD_ABS_MOVE,
                                  ssh_pkg::SSH_CMD_JOG_CW, ssh_pkg::SSH_CMD_JOG_CCW,
                                  ssh_pkg::SSH_CMD_HOME_CW, ssh_pkg::SSH_CMD_HOME_CCW};
  assign refuse    = cmd_valid_in && (
                     (code == ssh_pkg::SSH_CMD_ABS_MOVE && !homed_out) ||
                     (is_move && state != SSH_M_IDLE) ||
                     ((code == ssh_pkg::SSH_CMD_PRESET_MOTOR ||
                       code == ssh_pkg::SSH_CMD_PRESET_ENC) && !in_range) ||
                     (profile_in.jerk > `SSH_JERK_MAX && is_move));
  assign take      = cmd_valid_in && !refuse;
  assign enc_ok    = encoder_fitted_in && config_in.encoder_en;
  assign hw_stall  = stall_in && enc_ok && config_in.stall_en;
  assign home_edge = home_sensor_in && !home_prev;
  assign phase_sum = {1'b0, phase} + {1'b0, speed_out};
  assign scaled    = (48'(signed'(enc_pos_out)) * 48'(signed'({8'h00, config_in.steps_per_turn})))
                     / 48'(signed'({8'h00, config_in.counts_per_turn}));
  assign enc_scaled = (config_in.counts_per_turn == 16'h0000) ? enc_pos_out : scaled[23:0];
  assign ramp_accel = (state == SSH_M_DEC) ? profile_in.decel : profile_in.accel;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= div == '0;
      div  <= (div == '0) ? ($clog2(TICK_CYC+1))'(TICK_CYC - 1) : div - 1'b1;
    end
  end

  ssh_ramp #(.W(24)) u_ramp (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .tick_in   (tick),
    .start_in  (ramp_start),
    .from_in   (ramp_from),
    .to_in     (ramp_to),
    .accel_in  (ramp_accel),
    .jerk_in   (profile_in.jerk),
    .speed_out (ramp_speed),
    .busy_out  (ramp_busy)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state           <= SSH_M_IDLE;
      ramp_start      <= 1'b0;
      ramp_from       <= '0;
      ramp_to         <= '0;
      phase           <= '0;
      step_out        <= 1'b0;
      dir_cw_out      <= 1'b1;
      homing          <= 1'b0;
      jogging         <= 1'b0;
      remaining       <= '0;
      home_prev       <= 1'b0;
      jog_current     <= '0;
      motor_pos_out   <= '0;
      enc_pos_out     <= '0;
      homed_out       <= 1'b0;
      pos_invalid_out <= 1'b1;
      stall_out       <= 1'b0;
      cmd_refused_out <= 1'b0;
    end else begin
      ramp_start      <= 1'b0;
      home_prev       <= home_sensor_in;
      cmd_refused_out <= refuse;
      if (hw_stall) begin
        stall_out <= 1'b1;
      end else if (take && code == ssh_pkg::SSH_CMD_CLEAR_ERR) begin
        stall_out <= 1'b0;
      end
      if (enc_ok && enc_step_in) begin
        enc_pos_out <= enc_dir_in ? enc_pos_out + 24'sd1 : enc_pos_out - 24'sd1;
      end
      step_out <= 1'b0;
      if (state != SSH_M_IDLE && tick) begin
        phase <= phase_sum[23:0];
      end
      if (state != SSH_M_IDLE && phase_sum[24] && tick) begin
        step_out      <= 1'b1;
        motor_pos_out <= dir_cw_out ? motor_pos_out + 24'sd1 : motor_pos_out - 24'sd1;
        remaining     <= remaining - 24'sd1;
      end
      unique case (state)
        SSH_M_IDLE: begin
          jogging <= 1'b0;
          if (take && is_move) begin
            dir_cw_out <= code == ssh_pkg::SSH_CMD_JOG_CW || code == ssh_pkg::SSH_CMD_HOME_CW
                          || ((code == ssh_pkg::SSH_CMD_REL_MOVE) && cmd_in.value >= 0)
                          || ((code == ssh_pkg::SSH_CMD_ABS_MOVE) &&
                              cmd_in.value >= motor_pos_out);
            homing     <= code == ssh_pkg::SSH_CMD_HOME_CW || code == ssh_pkg::SSH_CMD_HOME_CCW;
            jogging    <= code == ssh_pkg::SSH_CMD_JOG_CW || code == ssh_pkg::SSH_CMD_JOG_CCW;
            jog_current <= cmd_in.current;
            remaining  <= (code == ssh_pkg::SSH_CMD_ABS_MOVE) ? cmd_in.value - motor_pos_out :
                          (cmd_in.value < 0 ? -cmd_in.value : cmd_in.value);
            if (code == ssh_pkg::SSH_CMD_ABS_MOVE && cmd_in.value < motor_pos_out) begin
              remaining <= motor_pos_out - cmd_in.value;
            end
            phase      <= '0;
            ramp_from  <= profile_in.start_speed;
            ramp_to    <= profile_in.prog_speed;
            ramp_start <= 1'b1;
            state      <= SSH_M_ACC;
          end else if (take && code == ssh_pkg::SSH_CMD_PRESET_MOTOR) begin
            motor_pos_out   <= cmd_in.value;
            pos_invalid_out <= 1'b0;
            homed_out       <= 1'b1;
          end else if (take && code == ssh_pkg::SSH_CMD_PRESET_ENC) begin
            enc_pos_out <= cmd_in.value;
          end else if (take && code == ssh_pkg::SSH_CMD_ENC_TO_MOTOR) begin
            motor_pos_out <= enc_scaled;
          end
        end
        SSH_M_ACC: begin
          if (!ramp_busy && !ramp_start) state <= SSH_M_RUN;
          if (homing && home_edge) begin
            ramp_from  <= speed_out;
            ramp_to    <= profile_in.start_speed;
            ramp_start <= 1'b1;
            state      <= SSH_M_DEC;
          end
        end
        SSH_M_RUN: begin
          if ((homing && home_edge) || (take && code == ssh_pkg::SSH_CMD_STOP) ||
              (!homing && !jogging && remaining <= 24'sd0)) begin
            ramp_from  <= speed_out;
            ramp_to    <= profile_in.start_speed;
            ramp_start <= 1'b1;
            state      <= SSH_M_DEC;
          end
        end
        SSH_M_DEC: begin
          if (!ramp_busy && !ramp_start) state <= homing ? SSH_M_SEEK : SSH_M_IDLE;
        end
        SSH_M_SEEK: begin
          if (home_edge) begin
            motor_pos_out <= '0;
            if (enc_ok) enc_pos_out <= '0;
            homed_out       <= 1'b1;
            pos_invalid_out <= 1'b0;
            homing          <= 1'b0;
            state           <= SSH_M_IDLE;
          end
        end
      endcase
    end
  end

  assign speed_out   = (state == SSH_M_IDLE) ? 24'h000000 :
                       (state == SSH_M_SEEK) ? profile_in.start_speed : ramp_speed;
  assign moving_out  = state != SSH_M_IDLE;
  assign current_out = jogging ? jog_current : 8'hff;
endmodule

// file: ssh_motion_assertions.sv
// Purpose: Port-level checks for ssh_motion
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every ssh_motion instance
`timescale 1ns/1ps
module ssh_motion_assertions #(
  parameter int TICK_CYC = 4
) (
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  cmd_valid_in,
  input wire ssh_pkg::ssh_command_t cmd_in,
  input wire ssh_pkg::ssh_profile_t profile_in,
  input wire ssh_pkg::ssh_config_t  config_in,
  input wire logic                  encoder_fitted_in,
  input wire logic                  home_sensor_in,
  input wire logic                  stall_in,
  input wire logic                  enc_step_in,
  input wire logic                  enc_dir_in,
  input wire logic                  cmd_refused_out,
  input wire logic [23:0]           speed_out,
  input wire logic                  dir_cw_out,
  input wire logic                  moving_out,
  input wire logic [7:0]            current_out,
  input wire logic signed [23:0]    motor_pos_out,
  input wire logic signed [23:0]    enc_pos_out,
  input wire logic                  homed_out,
  input wire logic                  pos_invalid_out,
  input wire logic                  stall_out,
  input wire logic                  step_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic home_run;
  // Marks a home search in progress, seen from the ports
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      home_run <= 1'b0;
    end else if (cmd_valid_in && !moving_out && profile_in.jerk <= 16'h1388 &&
                 cmd_in.code inside {ssh_pkg::SSH_CMD_HOME_CW, ssh_pkg::SSH_CMD_HOME_CCW}) begin
      home_run <= 1'b1;
    end else if (!moving_out) begin
      home_run <= 1'b0;
    end
  end
  sequence s_cmd(ssh_pkg::ssh_cmd_t c);
    cmd_valid_in && cmd_in.code == c;
  endsequence
  sequence s_go(ssh_pkg::ssh_cmd_t c);
    s_cmd(c) ##0 (!moving_out && profile_in.jerk <= 16'h1388);
  endsequence
  sequence s_home_done;
    (home_run && moving_out) ##1 !moving_out;
  endsequence
  abs_refuse_a: assert property (s_cmd(ssh_pkg::SSH_CMD_ABS_MOVE) ##0 !homed_out
    |=> cmd_refused_out) else $error("absolute move taken while unhomed");
  jerk_refuse_a: assert property (cmd_valid_in && profile_in.jerk > 16'h1388 && cmd_in.code
    inside {[ssh_pkg::SSH_CMD_REL_MOVE:ssh_pkg::SSH_CMD_HOME_CCW]} |=> cmd_refused_out)
    else $error("move with jerk above limit taken");
  range_refuse_a: assert property (s_cmd(ssh_pkg::SSH_CMD_PRESET_MOTOR) ##0
    cmd_in.value == 24'sh800000 |=> cmd_refused_out) else $error("preset out of range taken");
  preset_load_a: assert property (s_cmd(ssh_pkg::SSH_CMD_PRESET_MOTOR) ##0
    (cmd_in.value != 24'sh800000 && !moving_out)
    |=> motor_pos_out == $past(cmd_in.value) && !pos_invalid_out)
    else $error("motor preset not loaded");
  stall_hold_a: assert property (stall_out && !(cmd_valid_in &&
    cmd_in.code == ssh_pkg::SSH_CMD_CLEAR_ERR) |=> stall_out) else $error("stall flag dropped");
  stall_clear_a: assert property (s_cmd(ssh_pkg::SSH_CMD_CLEAR_ERR) ##0 !stall_in
    |=> !stall_out) else $error("stall flag not cleared");
  home_zero_a: assert property (s_home_done |-> motor_pos_out == 24'sh000000 && homed_out)
    else $error("motor position not zero after home");
  home_enc_a: assert property (s_home_done ##0 (config_in.encoder_en && encoder_fitted_in)
    |-> enc_pos_out == 24'sh000000) else $error("encoder position not zero after home");
  cw_start_a: assert property (s_go(ssh_pkg::SSH_CMD_HOME_CW) |=> moving_out && dir_cw_out)
    else $error("clockwise search did not start clockwise");
  ccw_start_a: assert property (s_go(ssh_pkg::SSH_CMD_HOME_CCW) |=> moving_out && !dir_cw_out)
    else $error("counterclockwise search did not start counterclockwise");
endmodule
bind ssh_motion ssh_motion_assertions #(.TICK_CYC(TICK_CYC)) chk (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .profile_in(profile_in),
  .config_in(config_in), .encoder_fitted_in(encoder_fitted_in), .home_sensor_in(home_sensor_in),
  .stall_in(stall_in), .enc_step_in(enc_step_in), .enc_dir_in(enc_dir_in),
  .cmd_refused_out(cmd_refused_out), .speed_out(speed_out), .dir_cw_out(dir_cw_out),
  .moving_out(moving_out), .current_out(current_out), .motor_pos_out(motor_pos_out),
  .enc_pos_out(enc_pos_out), .homed_out(homed_out), .pos_invalid_out(pos_invalid_out),
  .stall_out(stall_out), .step_out(step_out));

// file: ssh_far_side.sv
// Purpose: Motor side model: home sensor and encoder
// Assumes: Sensor flag recurs while the shaft turns
// Notes:   Encoder follows step pulses one cycle late
`timescale 1ns/1ps
module ssh_far_side (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic moving_in,
  input  wire logic dir_cw_in,
  input  wire logic step_in,
  output logic      home_sensor_out,
  output logic      enc_step_out,
  output logic      enc_dir_out
);
  logic [5:0] phase;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= 6'h00;
      enc_step_out <= 1'b0;
    end else begin
      phase <= moving_in ? phase + 6'h01 : 6'h00;
      enc_step_out <= step_in;
    end
  end
  assign home_sensor_out = (phase[5:2] == 4'hf);
  assign enc_dir_out = dir_cw_in;
endmodule

// file: testbench.sv
// Purpose: Self-checking bench for ssh_motion
// Assumes: TICK_CYC shortened to 4
// Notes:   Random preset values from a fixed seed
`timescale 1ns/1ps
module testbench;
  logic                  mclk_in, rst_n_in, cmd_valid_in, encoder_fitted_in, stall_in;
  logic                  home_sensor_in, enc_step_in, enc_dir_in, cmd_refused_out, dir_cw_out;
  logic                  moving_out, homed_out, pos_invalid_out, stall_out, step_out;
  logic [23:0]           speed_out, v;
  logic [7:0]            current_out;
  logic signed [23:0]    motor_pos_out, enc_pos_out;
  ssh_pkg::ssh_command_t cmd_in;
  ssh_pkg::ssh_profile_t profile_in;
  ssh_pkg::ssh_config_t  config_in;
  int                    num_errors = 0;
  int                    cmp_count = 0;
  int                    k;
  int                    steps = 0;
  ssh_motion #(.TICK_CYC(4)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .profile_in(profile_in),
    .config_in(config_in), .encoder_fitted_in(encoder_fitted_in),
    .home_sensor_in(home_sensor_in), .stall_in(stall_in), .enc_step_in(enc_step_in),
    .enc_dir_in(enc_dir_in), .cmd_refused_out(cmd_refused_out), .speed_out(speed_out),
    .dir_cw_out(dir_cw_out), .moving_out(moving_out), .current_out(current_out),
    .motor_pos_out(motor_pos_out), .enc_pos_out(enc_pos_out), .homed_out(homed_out),
    .pos_invalid_out(pos_invalid_out), .stall_out(stall_out), .step_out(step_out));
  ssh_far_side far (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .moving_in(moving_out),
    .dir_cw_in(dir_cw_out), .step_in(step_out), .home_sensor_out(home_sensor_in),
    .enc_step_out(enc_step_in), .enc_dir_out(enc_dir_in));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (step_out === 1'b1) steps++;
  end
  function automatic logic [23:0] scaled(int enc, int steps, int counts);
    return 24'(enc * steps / counts);
  endfunction
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(ssh_pkg::ssh_cmd_t c, logic [23:0] val, logic [7:0] cur);
    @(negedge mclk_in);
    cmd_valid_in = 1'b1;
    cmd_in = '{c, val, cur};
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (moving_out !== 1'b0 && n < 4000) begin
      @(negedge mclk_in);
      n++;
    end
    check("idle", 24'(moving_out), 24'h000000);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #5000000;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    stall_in = 1'b0;
    encoder_fitted_in = 1'b1;
    profile_in = '{24'h400000, 24'h800000, 24'h200000, 24'h200000, 16'h0000};
    config_in = '{16'h07d0, 16'h1000, 1'b1, 1'b1};
    rst_n_in = 1'b0;
    void'($urandom(32'h7258));
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'b1;
    check("pos_invalid", 24'(pos_invalid_out), 24'h000001);
    check("homed", 24'(homed_out), 24'h000000);
    send(ssh_pkg::SSH_CMD_ABS_MOVE, 24'h000010, 8'hff);
    check("abs refused", 24'(cmd_refused_out), 24'h000001);
    profile_in.jerk = 16'h1389;
    send(ssh_pkg::SSH_CMD_REL_MOVE, 24'h000010, 8'hff);
    check("jerk refused", 24'(cmd_refused_out), 24'h000001);
    profile_in.jerk = 16'h1388;
    send(ssh_pkg::SSH_CMD_REL_MOVE, 24'h000010, 8'hff);
    check("rel taken", 24'(moving_out), 24'h000001);
    wait_idle();
    profile_in.jerk = 16'h0000;
    $display("test refusals done");
    for (k = 0; k < 6; k++) begin
      v = (k == 0) ? 24'h7fffff : (k == 1) ? 24'h800001 :
          24'($urandom_range(24'hfffffe, 0)) - 24'h7fffff;
      send(ssh_pkg::SSH_CMD_PRESET_MOTOR, v, 8'hff);
      check("motor preset", motor_pos_out, v);
      check("pos_invalid", 24'(pos_invalid_out), 24'h000000);
      send(ssh_pkg::SSH_CMD_PRESET_ENC, 24'h000000 - v, 8'hff);
      check("enc preset", enc_pos_out, 24'h000000 - v);
    end
    send(ssh_pkg::SSH_CMD_PRESET_MOTOR, 24'h800000, 8'hff);
    check("range refused", 24'(cmd_refused_out), 24'h000001);
    check("motor kept", motor_pos_out, v);
    k = $urandom_range(100, 1);
    send(ssh_pkg::SSH_CMD_PRESET_ENC, 24'(k * 4096), 8'hff);
    send(ssh_pkg::SSH_CMD_ENC_TO_MOTOR, 24'h000000, 8'hff);
    check("scaled copy", motor_pos_out, scaled(k * 4096, 2000, 4096));
    $display("test presets done");
    send(ssh_pkg::SSH_CMD_JOG_CW, 24'h000000, 8'h20);
    check("jog current", 24'(current_out), 24'h000020);
    repeat (30) @(negedge mclk_in);
    check("jog current held", 24'(current_out), 24'h000020);
    check("jog speed", speed_out, 24'h800000);
    stall_in = 1'b1;
    @(negedge mclk_in);
    stall_in = 1'b0;
    check("stall set", 24'(stall_out), 24'h000001);
    send(ssh_pkg::SSH_CMD_STOP, 24'h000000, 8'hff);
    wait_idle();
    check("stall held", 24'(stall_out), 24'h000001);
    send(ssh_pkg::SSH_CMD_CLEAR_ERR, 24'h000000, 8'hff);
    check("stall cleared", 24'(stall_out), 24'h000000);
    $display("test stall done");
    send(ssh_pkg::SSH_CMD_HOME_CW, 24'h000000, 8'hff);
    check("cw start", 24'(dir_cw_out), 24'h000001);
    wait_idle();
    check("home motor", motor_pos_out, 24'h000000);
    check("home enc", enc_pos_out, 24'h000000);
    check("cw end", 24'(dir_cw_out), 24'h000001);
    check("homed", 24'(homed_out), 24'h000001);
    send(ssh_pkg::SSH_CMD_ABS_MOVE, 24'h000010, 8'hff);
    steps = 0;
    check("abs taken", 24'(cmd_refused_out), 24'h000000);
    wait_idle();
    @(negedge mclk_in);
    check("abs reach", 24'(motor_pos_out >= 24'sd16), 24'h000001);
    check("abs steps", motor_pos_out, 24'(steps));
    config_in.encoder_en = 1'b0;
    send(ssh_pkg::SSH_CMD_PRESET_ENC, 24'h400000, 8'hff);
    send(ssh_pkg::SSH_CMD_HOME_CCW, 24'h000000, 8'hff);
    check("ccw start", 24'(dir_cw_out), 24'h000000);
    wait_idle();
    check("ccw motor", motor_pos_out, 24'h000000);
    check("enc kept", 24'(enc_pos_out === 24'sh000000), 24'h000000);
    $display("test homing done");
    rst_n_in = 1'b0;
    @(negedge mclk_in);
    check("pos_invalid", 24'(pos_invalid_out), 24'h000001);
    check("homed reset", 24'(homed_out), 24'h000000);
    rst_n_in = 1'b1;
    wrap_up();
  end
endmodule
